// File: dbgdec_pkg.sv
`timescale 1ns/1ps

package dbgdec_pkg;

   // fixed base of the debug access interface in the system map
   localparam logic [31:0] DAI_BASE        = 32'hf000_0000;

   // clock and target watchdog timing
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          TGT_TIMEOUT_NS  = 10000;
   localparam logic [9:0]  TGT_TIMEOUT_CYC = 10'(TGT_TIMEOUT_NS / CLK_PERIOD_NS);

   // decoded address windows, one matcher each
   localparam int RG_SYS_ROM    = 0;
   localparam int RG_SYS_FUNNEL = 1;
   localparam int RG_SYS_CTI    = 2;
   localparam int RG_APB_EXP    = 3;
   localparam int RG_CORE_ROM   = 4;
   localparam int RG_CORE_PWR   = 5;
   localparam int RG_CERT       = 6;
   localparam int RG_AP_SYS     = 7;
   localparam int RG_AP_CPU0    = 8;
   localparam int RG_AP_CPU1    = 9;
   localparam int REGION_COUNT  = 10;

   // window bounds; the access port windows are offsets above the base
   localparam logic [31:0] REGION_BASE [REGION_COUNT] = '{
      32'hf000_0000, 32'hf000_1000, 32'hf000_2000, 32'hf008_0000, 32'hf000_8000,
      32'hf000_9000, 32'h3000_0000, 32'h0000_0000, 32'h0000_0100, 32'h0000_0200};
   localparam logic [31:0] REGION_LAST [REGION_COUNT] = '{
      32'hf000_0fff, 32'hf000_10ff, 32'hf000_2fff, 32'hf00f_ffff, 32'hf000_8fff,
      32'hf000_9fff, 32'h3000_1fff, 32'h0000_00ff, 32'h0000_01ff, 32'h0000_02ff};

   // one-hot target select positions
   localparam int T_SYS_ROM     = 0;
   localparam int T_SYS_FUNNEL  = 1;
   localparam int T_SYS_CTI     = 2;
   localparam int T_APB_EXP     = 3;
   localparam int T_CORE0_ROM   = 4;
   localparam int T_CORE0_PWR   = 5;
   localparam int T_CERT_WINDOW = 6;
   localparam int T_CORE0_MEM   = 7;
   localparam int T_CORE1_ROM   = 8;
   localparam int T_CORE1_PWR   = 9;
   localparam int T_CORE1_MEM   = 10;
   localparam int TGT_COUNT     = 11;

   // transaction phases
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ACCESS
   } dbgdec_phase_e;

   // request from the debug port master
   typedef struct packed {
      logic [31:0] ap_addr;
      logic [31:0] addr;
      logic        write;
      logic [31:0] wdata;
   } dbgdec_req_s;

   // request forwarded to a target
   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic [31:0] wdata;
   } dbgdec_xfer_s;

   // whole state of the decoder
   typedef struct packed {
      dbgdec_phase_e          phase;
      logic [TGT_COUNT-1:0]   sel;
      dbgdec_xfer_s           xfer;
      logic                   mask_read;
      logic                   done;
      logic                   error;
      logic [31:0]            rdata;
      logic [9:0]             wait_cnt;
   } dbgdec_state_s;

   localparam dbgdec_state_s STATE_RESET = '0;

endpackage : dbgdec_pkg

module dbgdec_match #(
   parameter logic [31:0] BASE = 32'h0000_0000,
   parameter logic [31:0] LAST = 32'h0000_0000
) (
   // address under test
   input  wire logic [31:0] addr,
   // inside the window
   output logic             hit
);

   // inclusive bounds compare
   assign hit = (addr >= BASE) && (addr <= LAST);

endmodule : dbgdec_match

// File: dbgdec_top.sv
`timescale 1ns/1ps

// Function
// - access interface sits at fixed system base
// - offsets 0x000-0x0ff pick system port
// - offsets 0x100-0x1ff pick core0 port
// - 0x200-0x2ff core1 port, above reserved
// - system port reaches debug subsystem components
// - system rom table at f000_0000, 4KB
// - trace funnel at f000_1000, 256 bytes
// - cross trigger at f000_2000 to 2fff
// - 512KB expansion window forwarded to apb
// - core0 port serves debug and certification
// - certification disable level picks core0 map
// - 8KB certificate window at 3000_0000 when enabled
// - window writes accepted, reads zero unless enabled
// - certificate window goes straight to sram
// - core0 rom table and power requester decoded
// - disabled map passes all else to memory
// - core1 rom table and power requester decoded
// - other core1 addresses go to memory
module dbgdec_top (
   // clock and reset
   input  wire logic                              MCLK,
   input  wire logic                              RESETN,
   // debug port master request
   input  wire logic                              DAP_REQ,
   input  wire dbgdec_pkg::dbgdec_req_s           DAP_XFER,
   output logic                                   DAP_READY,
   // debug port master answer
   output logic                                   DAP_DONE,
   output logic                                   DAP_ERROR,
   output logic [31:0]                            DAP_RDATA,
   // certification straps
   input  wire logic                              CERTIFICATION_DISABLE,
   input  wire logic                              CERTIFICATE_READ_ENABLE,
   // target side
   output logic                                   TGT_REQ,
   output logic [dbgdec_pkg::TGT_COUNT-1:0]       TGT_SEL,
   output dbgdec_pkg::dbgdec_xfer_s               TGT_XFER,
   input  wire logic                              TGT_ACK,
   input  wire logic                              TGT_ERR,
   input  wire logic [31:0]                       TGT_RDATA
);

   dbgdec_pkg::dbgdec_state_s                state;
   dbgdec_pkg::dbgdec_state_s                next_state;
   logic [dbgdec_pkg::REGION_COUNT-1:0]      hit;
   logic [31:0]                              ap_offset;
   logic                                     base_ok;
   logic [dbgdec_pkg::TGT_COUNT-1:0]         decode_sel;

   // access port offset is the low half above the fixed base
   assign base_ok   = (DAP_XFER.ap_addr[31:16] == dbgdec_pkg::DAI_BASE[31:16]);
   assign ap_offset = {16'h0000, DAP_XFER.ap_addr[15:0]};

   // one window matcher per decoded region
   for (genvar g = 0; g < dbgdec_pkg::REGION_COUNT; g++)
   begin : g_match
      dbgdec_match #(
         .BASE (dbgdec_pkg::REGION_BASE[g]),
         .LAST (dbgdec_pkg::REGION_LAST[g])
      ) u_match (
         .addr (g >= dbgdec_pkg::RG_AP_SYS ? ap_offset : DAP_XFER.addr),
         .hit  (hit[g])
      );
   end

   // target decode of the presented request
   always_comb
   begin
      decode_sel = '0;
      if (!base_ok)
      begin
         decode_sel = '0;
      end
      else if (hit[dbgdec_pkg::RG_AP_SYS])
      begin
         // system port map of debug components
         if (hit[dbgdec_pkg::RG_SYS_ROM])
         begin
            decode_sel[dbgdec_pkg::T_SYS_ROM] = 1'b1;
         end
         else if (hit[dbgdec_pkg::RG_SYS_FUNNEL])
         begin
            decode_sel[dbgdec_pkg::T_SYS_FUNNEL] = 1'b1;
         end
         else if (hit[dbgdec_pkg::RG_SYS_CTI])
         begin
            decode_sel[dbgdec_pkg::T_SYS_CTI] = 1'b1;
         end
         else if (hit[dbgdec_pkg::RG_APB_EXP])
         begin
            decode_sel[dbgdec_pkg::T_APB_EXP] = 1'b1;
         end
      end
      else if (hit[dbgdec_pkg::RG_AP_CPU0])
      begin
         // map chosen by the strap level
         if (!CERTIFICATION_DISABLE && hit[dbgdec_pkg::RG_CERT])
         begin
            decode_sel[dbgdec_pkg::T_CERT_WINDOW] = 1'b1;
         end
         else if (hit[dbgdec_pkg::RG_CORE_ROM])
         begin
            decode_sel[dbgdec_pkg::T_CORE0_ROM] = 1'b1;
         end
         else if (hit[dbgdec_pkg::RG_CORE_PWR])
         begin
            decode_sel[dbgdec_pkg::T_CORE0_PWR] = 1'b1;
         end
         else
         begin
            decode_sel[dbgdec_pkg::T_CORE0_MEM] = 1'b1;
         end
      end
      else if (hit[dbgdec_pkg::RG_AP_CPU1])
      begin
         if (hit[dbgdec_pkg::RG_CORE_ROM])
         begin
            decode_sel[dbgdec_pkg::T_CORE1_ROM] = 1'b1;
         end
         else if (hit[dbgdec_pkg::RG_CORE_PWR])
         begin
            decode_sel[dbgdec_pkg::T_CORE1_PWR] = 1'b1;
         end
         else
         begin
            decode_sel[dbgdec_pkg::T_CORE1_MEM] = 1'b1;
         end
      end
   end

   // next state of the transaction sequencer
   always_comb
   begin
      next_state      = state;
      next_state.done = 1'b0;
      case (state.phase)
         dbgdec_pkg::PH_IDLE:
         begin
            if (DAP_REQ)
            begin
               next_state.xfer.addr  = DAP_XFER.addr;
               next_state.xfer.write = DAP_XFER.write;
               next_state.xfer.wdata = DAP_XFER.wdata;
               next_state.wait_cnt   = '0;
               // strap levels captured once per transaction
               next_state.mask_read  = decode_sel[dbgdec_pkg::T_CERT_WINDOW]
                                       && !CERTIFICATE_READ_ENABLE
                                       && !DAP_XFER.write;
               if (decode_sel == '0)
               begin
                  // reserved: answer at once, nothing forwarded
                  next_state.sel   = '0;
                  next_state.done  = 1'b1;
                  next_state.error = 1'b1;
                  next_state.rdata = 32'h0000_0000;
               end
               else
               begin
                  next_state.sel   = decode_sel;
                  next_state.phase = dbgdec_pkg::PH_ACCESS;
               end
            end
         end
         dbgdec_pkg::PH_ACCESS:
         begin
            if (TGT_ACK)
            begin
               next_state.phase = dbgdec_pkg::PH_IDLE;
               next_state.sel   = '0;
               next_state.done  = 1'b1;
               next_state.error = TGT_ERR;
               // masked certificate reads return zero
               next_state.rdata = state.mask_read ? 32'h0000_0000 : TGT_RDATA;
            end
            else if (state.wait_cnt == dbgdec_pkg::TGT_TIMEOUT_CYC - 10'd1)
            begin
               // silent target: give up with an error
               next_state.phase = dbgdec_pkg::PH_IDLE;
               next_state.sel   = '0;
               next_state.done  = 1'b1;
               next_state.error = 1'b1;
               next_state.rdata = 32'h0000_0000;
            end
            else
            begin
               next_state.wait_cnt = state.wait_cnt + 10'd1;
            end
         end
         default:
         begin
            next_state = dbgdec_pkg::STATE_RESET;
         end
      endcase
   end

   // state register
   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state <= dbgdec_pkg::STATE_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   // outputs from state
   assign DAP_READY = (state.phase == dbgdec_pkg::PH_IDLE);
   assign DAP_DONE  = state.done;
   assign DAP_ERROR = state.error;
   assign DAP_RDATA = state.rdata;
   assign TGT_REQ   = (state.phase == dbgdec_pkg::PH_ACCESS);
   assign TGT_SEL   = state.sel;
   assign TGT_XFER  = state.xfer;

endmodule : dbgdec_top

// File: dbgdec_properties.sv
`timescale 1ns/1ps
module dbgdec_properties (
   // clock and reset
   input wire logic                            MCLK,
   input wire logic                            RESETN,
   // master side
   input wire logic                            DAP_REQ,
   input wire dbgdec_pkg::dbgdec_req_s         DAP_XFER,
   input wire logic                            DAP_READY,
   input wire logic                            DAP_DONE,
   input wire logic                            DAP_ERROR,
   input wire logic [31:0]                     DAP_RDATA,
   // straps
   input wire logic                            CERTIFICATION_DISABLE,
   input wire logic                            CERTIFICATE_READ_ENABLE,
   // target side
   input wire logic                            TGT_REQ,
   input wire logic [dbgdec_pkg::TGT_COUNT-1:0] TGT_SEL,
   input wire dbgdec_pkg::dbgdec_xfer_s        TGT_XFER,
   input wire logic                            TGT_ACK,
   input wire logic                            TGT_ERR,
   input wire logic [31:0]                     TGT_RDATA
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   // accepted request and the port it selects
   wire        take = DAP_REQ && DAP_READY;
   wire [15:0] off  = DAP_XFER.ap_addr[15:0];
   wire        inif = DAP_XFER.ap_addr[31:16] == 16'hf000;
   wire        sys  = take && inif && off[15:8] == 8'h00;
   wire        cp0  = take && inif && off[15:8] == 8'h01;
   wire        cp1  = take && inif && off[15:8] == 8'h02;
   wire [31:0] a    = DAP_XFER.addr;
   property p_rsv; take && inif && off >= 16'h0300
      |=> DAP_DONE && DAP_ERROR && DAP_RDATA == 32'h0 && !TGT_REQ; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved offset not refused");
   property p_srom; sys && a[31:12] == 20'hf0000 |=> TGT_REQ && TGT_SEL == 11'h001; endproperty
   a_srom: assert property (p_srom) else $error("system rom not selected");
   property p_fun; sys && a[31:8] == 24'hf00010 |=> TGT_SEL == 11'h002; endproperty
   a_fun: assert property (p_fun) else $error("trace funnel not selected");
   property p_cti; sys && a[31:12] == 20'hf0002 |=> TGT_SEL == 11'h004; endproperty
   a_cti: assert property (p_cti) else $error("cross trigger not selected");
   property p_apb; sys && a[31:19] == 13'h1e01 |=> TGT_SEL == 11'h008; endproperty
   a_apb: assert property (p_apb) else $error("expansion not selected");
   property p_cert; cp0 && !CERTIFICATION_DISABLE && a[31:13] == 19'h18000
      |=> TGT_SEL == 11'h040 && TGT_XFER.addr == $past(a); endproperty
   a_cert: assert property (p_cert) else $error("certificate window not selected");
   property p_coff; cp0 && CERTIFICATION_DISABLE && a[31:13] == 19'h18000 |=> TGT_SEL == 11'h080; endproperty
   a_coff: assert property (p_coff) else $error("disabled map not memory");
   property p_c0pw; cp0 && a[31:12] == 20'hf0009 |=> TGT_SEL == 11'h020; endproperty
   a_c0pw: assert property (p_c0pw) else $error("core0 power requester not selected");
   property p_c1rom; cp1 && a[31:12] == 20'hf0008 |=> TGT_SEL == 11'h100; endproperty
   a_c1rom: assert property (p_c1rom) else $error("core1 rom not selected");
   property p_c1mem; cp1 && a[31:12] == 20'hf000a |=> TGT_SEL == 11'h400; endproperty
   a_c1mem: assert property (p_c1mem) else $error("core1 memory not selected");
   property p_mask; TGT_REQ && TGT_ACK && TGT_SEL[6] && !TGT_XFER.write && !CERTIFICATE_READ_ENABLE
      |=> DAP_DONE && DAP_RDATA == 32'h0; endproperty
   a_mask: assert property (p_mask) else $error("certificate read not masked");
   property p_ack; TGT_REQ && TGT_ACK && !TGT_SEL[6]
      |=> DAP_DONE && !TGT_REQ && DAP_RDATA == $past(TGT_RDATA) && DAP_ERROR == $past(TGT_ERR); endproperty
   a_ack: assert property (p_ack) else $error("target answer not passed back");
endmodule : dbgdec_properties

bind dbgdec_top dbgdec_properties u_props (.*);

// File: dbgdec_target.sv
`timescale 1ns/1ps
module dbgdec_target (
   // clock, reset and stall control
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    stall,
   // access from the decoder
   input wire logic                    req,
   input wire dbgdec_pkg::dbgdec_xfer_s xfer,
   output logic                        ack,
   output logic                        err,
   output logic [31:0]                 rdata
);
   logic [1:0] cnt;
   // cycles spent on the outstanding access
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) cnt <= 2'h0;
      else cnt <= req ? cnt + 2'h1 : 2'h0;
   end
   // answer after addr[1:0] cycles; idle lines carry junk
   assign ack   = req && !stall && cnt == xfer.addr[1:0];
   assign err   = ack ? xfer.addr[7:0] == 8'hee : ~xfer.addr[8];
   assign rdata = ack ? {xfer.addr[15:0], xfer.addr[31:16]} : ~xfer.addr ^ {30'h0, cnt};
endmodule : dbgdec_target

// File: tb_debug_access_address_decoder.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) \
   begin failures++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb_debug_access_address_decoder;
   logic mclk, resetn, req, ready, done, error, cd, re, stall, treq, tack, terr;
   logic [31:0] rdata, trdata, r;
   logic [10:0] tsel;
   dbgdec_pkg::dbgdec_req_s  xfer;
   dbgdec_pkg::dbgdec_xfer_s txfer;
   int failures, n_checks, seed, i;
   logic [64:0] tbl [20] = '{
      {1'b0, 64'hf000_0000_f000_0ffc}, {1'b0, 64'hf000_00ff_f000_1000}, {1'b0, 64'hf000_0000_f000_1100},
      {1'b0, 64'hf000_0040_f000_2ffe}, {1'b0, 64'hf000_0000_f008_0000}, {1'b0, 64'hf000_0000_f00f_ffff},
      {1'b0, 64'hf000_0000_f010_0000}, {1'b0, 64'hf000_0000_efff_ffff}, {1'b0, 64'hf000_0100_3000_0000},
      {1'b0, 64'hf000_01ff_3000_1fff}, {1'b0, 64'hf000_0100_3000_2000}, {1'b1, 64'hf000_0100_3000_0001},
      {1'b1, 64'hf000_0100_f000_8000}, {1'b0, 64'hf000_0100_f000_9fff}, {1'b1, 64'hf000_0100_f000_a002},
      {1'b0, 64'hf000_02ff_f000_8fff}, {1'b1, 64'hf000_0200_f000_9001}, {1'b0, 64'hf000_0200_0000_00ee},
      {1'b0, 64'hf000_0300_f000_0000}, {1'b0, 64'hf001_0100_3000_0000}};
   dbgdec_top u_dut (.MCLK(mclk), .RESETN(resetn), .DAP_REQ(req), .DAP_XFER(xfer), .DAP_READY(ready),
      .DAP_DONE(done), .DAP_ERROR(error), .DAP_RDATA(rdata), .CERTIFICATION_DISABLE(cd),
      .CERTIFICATE_READ_ENABLE(re), .TGT_REQ(treq), .TGT_SEL(tsel), .TGT_XFER(txfer), .TGT_ACK(tack),
      .TGT_ERR(terr), .TGT_RDATA(trdata));
   dbgdec_target u_tgt (.clk(mclk), .rst_n(resetn), .stall(stall), .req(treq), .xfer(txfer), .ack(tack),
      .err(terr), .rdata(trdata));
   // free running clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // reference decode: target index, or -1 when refused
   function automatic int exp_sel(input logic [31:0] ap, input logic [31:0] a, input logic c);
      if (ap[31:16] != 16'hf000 || ap[15:0] >= 16'h0300) return -1;
      if (ap[15:8] == 8'h00)
      begin
         if (a[31:12] == 20'hf0000) return 0;
         if (a[31:8] == 24'hf00010) return 1;
         if (a[31:12] == 20'hf0002) return 2;
         if (a[31:19] == 13'h1e01) return 3;
         return -1;
      end
      if (a[31:12] == 20'hf0008) return ap[9] ? 8 : 4;
      if (a[31:12] == 20'hf0009) return ap[9] ? 9 : 5;
      if (!ap[9] && !c && a[31:13] == 19'h18000) return 6;
      return ap[9] ? 10 : 7;
   endfunction : exp_sel
   // closing report
   task print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   // one access and its comparisons
   task automatic access(input logic [31:0] ap, input logic [31:0] a, input logic wr, c, rd, stl);
      int          sel, k;
      logic [31:0] wd;
      sel = exp_sel(ap, a, c);
      wd  = $random(seed);
      @(posedge mclk);
      req <= 1'b1;
      xfer <= '{ap, a, wr, wd};
      cd <= c;
      re <= rd;
      stall <= stl;
      @(posedge mclk);
      req <= 1'b0;
      // look mid-cycle, away from the edge that moves the outputs
      @(negedge mclk);
      `CHK("sel", tsel, (sel < 0) ? 11'h0 : 11'h1 << sel)
      `CHK("ready", ready, sel < 0)
      if (sel >= 0) `CHK("taddr", txfer.addr, a)
      if (sel >= 0) `CHK("twrite", txfer.write, wr)
      if (sel >= 0) `CHK("twdata", txfer.wdata, wd)
      for (k = 0; k < 1100 && done !== 1'b1; k++) @(negedge mclk);
      if (k == 1100)
      begin
         failures++;
         print_verdict;
      end
      `CHK("error", error, sel < 0 || stl || a[7:0] == 8'hee)
      `CHK("rdata", rdata, (sel < 0 || stl || (sel == 6 && !wr && !rd)) ? 32'h0 : {a[15:0], a[31:16]})
   endtask : access
   // main sequence
   initial
   begin
      {resetn, req, cd, re, stall, xfer, failures, n_checks} = '0;
      seed = 23929;
      repeat (10) @(posedge mclk);
      `CHK("ready", ready, 1'b1)
      `CHK("rst_sel", tsel, 11'h0)
      resetn <= 1'b1;
      for (i = 0; i < 60; i++) access(tbl[i/3][63:32], tbl[i/3][31:0], i % 3 == 2, tbl[i/3][64], i % 3 == 1, 1'b0);
      access(32'hf000_0200, 32'h1000_0000, 1'b0, 1'b0, 1'b1, 1'b1);
      access(32'hf000_0200, 32'hf000_a004, 1'b0, 1'b0, 1'b1, 1'b0);
      for (i = 0; i < 200; i++)
      begin
         r = $random(seed);
         access({16'hf000, 6'h0, r[9:8], 8'h10}, r[29] ? {12'hf00, r[27:8]} : {r[28] ? 19'h18000 : 19'h0, r[12:0]},
            r[2], r[0], r[1], 1'b0);
      end
      print_verdict;
   end
endmodule : tb_debug_access_address_decoder
